//--- fdp_defines.svh
// register offsets, field positions, reset values and timing for the port
`ifndef FDP_DEFINES_SVH
`define FDP_DEFINES_SVH

// register indexes on the plain register port
`define FDP_OFS_DRIVE_CTRL 3'h0
`define FDP_OFS_DRIVE_STAT 3'h1
`define FDP_OFS_PORT_CFG   3'h2
`define FDP_OFS_ID_CMD     3'h3
`define FDP_OFS_ID_BYTE0   3'h4
`define FDP_OFS_ID_BYTE1   3'h5
`define FDP_OFS_ID_BYTE2   3'h6
`define FDP_OFS_ID_BYTE3   3'h7

// drive control byte: motor 7, selects 6..3, side 2, direction 1, step 0
`define FDP_BIT_MOTOR      7
`define FDP_BIT_SEL_EXT3   6
`define FDP_BIT_SEL_INT    3
`define FDP_BIT_SIDE       2
`define FDP_BIT_DIR        1
`define FDP_BIT_STEP       0
`define FDP_RST_DRIVE_CTRL 8'hFD

// drive status byte: ready 5, track zero 4, write protect 3, change 2
`define FDP_BIT_READY      5
`define FDP_BIT_TRK0       4
`define FDP_BIT_WPROT      3
`define FDP_BIT_CHANGE     2

// port configuration byte
`define FDP_BIT_IDX_EN     0
`define FDP_BIT_WGATE      1
`define FDP_RST_PORT_CFG   2'h0

// identification command byte
`define FDP_BIT_ID_START   7
`define FDP_BIT_ID_BUSY    7
`define FDP_ID_BITS        32

// motor data setup and hold around a select edge
`define FDP_CLK_NS         5
`define FDP_SETUP_NS       1400
`define FDP_SETUP_CYC      ((`FDP_SETUP_NS + `FDP_CLK_NS - 1) / `FDP_CLK_NS)

`endif

//--- fdp_drive_model.sv
// behavioural floppy drive sitting on external unit 1
module fdp_drive_model
  import fdp_pkg::*;
#(
  parameter logic [31:0] ID_WORD = 32'hC3A5_5A3C, // arbitrary value
  parameter bit          PROT    = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic sel_n_i,
  input  wire logic motor_n_i,
  input  wire logic step_n_i,
  input  wire logic dir_i,
  output logic      ready_n_o,
  output logic      trk0_n_o,
  output logic      wprot_n_o,
  output logic      chg_n_o,
  output logic      index_n_o,
  output logic      flux_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic motor = 1'b0;
  logic wp    = 1'b1;
  logic chg   = 1'b1; // set at power-up
  logic armed = 1'b0;
  int   cyl   = 0;
  int   bitn  = 0;
  int   tick  = 0;
  ////////////////////////////////////////////////////////////////////////
  // motor flop latched on select edge, id pointer cleared on on-to-off,
  // one id bit consumed per select release while the motor stays off
  always @(sel_n_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      motor <= 1'b0;
      wp    <= 1'b1;
    end else if (!sel_n_i) begin
      if (motor && motor_n_i) bitn <= 0;
      armed <= motor_n_i && !motor;
      motor <= !motor_n_i;
      if (!motor_n_i) wp <= PROT;
    end else if (armed) begin
      bitn  <= bitn + 1;
      armed <= 1'b0;
    end
  end
  // head moves one cylinder per step, disk always present
  always @(negedge step_n_i) begin
    if (!sel_n_i) begin
      cyl <= dir_i ? ((cyl > 0) ? cyl - 1 : 0) : cyl + 1;
      chg <= 1'b0;
    end
  end
  always @(posedge clk_i) tick <= tick + 1;
  // deselected lines float up to the pull-up
  always @* begin
    {ready_n_o, trk0_n_o, wprot_n_o, chg_n_o, index_n_o, flux_n_o} = '1;
    if (!sel_n_i) begin
      ready_n_o = motor ? 1'b0 : !(armed && ID_WORD[31-bitn]);
      trk0_n_o  = (cyl != 0);
      wprot_n_o = !wp;
      chg_n_o   = !chg;
      index_n_o = !(motor && tick[5:0] < 6'h4);
      flux_n_o  = !(motor && tick[2:0] == 3'h0);
    end
  end
endmodule

//--- fdp_id_shift.sv
// identification word collector, msb first, inverting each sample
module fdp_id_shift
  import fdp_pkg::*;
#(
  parameter int N = 32
) (
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  input  wire logic         clr_i,
  input  wire logic         shift_i,
  input  wire logic         bit_n_i,
  output logic      [N-1:0] id_o
);

  typedef struct packed {
    logic [N-1:0] word;
  } fdp_idsh_s;

  // the shift needs at least two bits of word
  if (N < 2) begin : g_chk_n
    $error("N must be at least 2");
  end

  fdp_idsh_s s_ff;
  fdp_idsh_s nxt_s;

  // clear on init, shift the inverted sample in at the bottom
  always_comb begin
    nxt_s = s_ff;
    if (clr_i) begin
      nxt_s.word = '0;
    end else if (shift_i) begin
      nxt_s.word = {s_ff.word[N-2:0], ~bit_n_i};
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign id_o = s_ff.word;

endmodule

//--- fdp_pkg.sv
// types shared by the floppy drive port control logic
package fdp_pkg;

  // drive control lines in port bit order, bit 7 first
  typedef struct packed {
    logic       motor_n;
    logic [3:0] sel_n;
    logic       side_n;
    logic       dir;
    logic       step_n;
  } fdp_drive_ctrl_s;

  // drive status inputs, all active low
  typedef struct packed {
    logic ready_n;
    logic trk0_n;
    logic wprot_n;
    logic chg_n;
    logic index_n;
    logic flux_n;
  } fdp_drive_stat_s;

  // identification sequencer
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_MON,
    ST_MON_SEL,
    ST_MON_REL,
    ST_MOFF,
    ST_MOFF_SEL,
    ST_MOFF_REL,
    ST_BIT_SEL,
    ST_BIT_REL
  } fdp_id_state_e;

endpackage

//--- fdp_port_ctrl.sv
// floppy drive port control: drive lines, status, flux and id reader
//
// Overview of operation
// - motor level is set up before a select edge latches it per drive
// - side line active picks head side 1, inactive side 0
// - each step pulse moves the head one cylinder per direction line
// - direction inactive steps inward, active steps outward
// - index edge can raise the level-6 interrupt request when enabled
// - write flux goes out only under write gate; read flux comes in
// - id starts with motor on then off; drive resets its shifter then
// - per bit: select on, sample ready, select off; 32 times
// - id bits come msb first, active low, and are inverted
// - three external drive selects plus one internal select
// - control byte: motor 7, selects 6..3, side 2, dir 1, step 0
// - status byte: ready 5, track zero 4, protect 3, change 2
//
// The address map and the strobed register port were chosen for this implementation.
`include "fdp_defines.svh"

module fdp_port_ctrl
  import fdp_pkg::*;
#(
  parameter int SETUP_CYC = `FDP_SETUP_CYC,
  parameter int ID_BITS   = `FDP_ID_BITS
) (
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  // register port
  input  wire logic [2:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // drive control lines
  output logic            spindle_on_n_o,
  output logic            internal_unit_select_n_o,
  output logic            external_unit1_select_n_o,
  output logic            external_unit2_select_n_o,
  output logic            external_unit3_select_n_o,
  output logic            head_side_n_o,
  output logic            head_direction_o,
  output logic            head_move_pulse_n_o,
  output logic            write_gate_n_o,
  output logic            write_flux_n_o,
  output logic            system_reset_out_n_o,
  // drive status lines
  input  wire logic       ready_n_i,
  input  wire logic       outer_cylinder_n_i,
  input  wire logic       write_protected_n_i,
  input  wire logic       media_changed_n_i,
  input  wire logic       index_n_i,
  input  wire logic       read_flux_n_i,
  // flux stream and index request on the system side
  input  wire logic       write_flux_i,
  output logic            read_flux_o,
  output logic            index_event_o
);

  ////////////////////////////////////////////////////////////////////////////
  // parameter checks

  if (SETUP_CYC < 1 || SETUP_CYC > 511) begin : g_chk_setup
    $error("SETUP_CYC must lie in 1..511");
  end
  if (ID_BITS != `FDP_ID_BITS) begin : g_chk_id
    $error("ID_BITS must be 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    fdp_drive_ctrl_s ctrl;
    logic            idx_en;
    logic            wgate;
    logic [7:0]      rdata;
    logic            rst_out;
    logic [8:0]      tmr;
    fdp_id_state_e   st;
    logic [1:0]      unit;
    logic [5:0]      bitno;
    logic            idx_prev;
    logic            idx_evt;
    logic            wflux_n;
    logic            rflux;
  } fdp_port_s;

  fdp_port_s s_ff;
  fdp_port_s nxt_s;

  fdp_drive_stat_s stat;
  logic [31:0]     id_word;
  logic            id_clr;
  logic            id_shift;
  fdp_drive_ctrl_s wr_ctrl;
  logic [3:0]      sel_fsm;
  logic            busy;
  logic            tmr_done;
  logic [8:0]      setup_val;

  assign setup_val = 9'(SETUP_CYC);
  assign busy      = (s_ff.st != ST_IDLE);
  assign tmr_done  = (s_ff.tmr == 9'h000);
  assign wr_ctrl   = fdp_drive_ctrl_s'(reg_wdata_i);

  ////////////////////////////////////////////////////////////////////////////
  // status input synchroniser

  fdp_sync2 #(
    .W       (6),
    .RST_VAL (6'h3F)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .async_i   ({ready_n_i, outer_cylinder_n_i, write_protected_n_i,
                 media_changed_n_i, index_n_i, read_flux_n_i}),
    .sync_o    (stat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // identification word collector

  fdp_id_shift #(
    .N (32)
  ) u_id (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .clr_i     (id_clr),
    .shift_i   (id_shift),
    .bit_n_i   (stat.ready_n),
    .id_o      (id_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_s         = s_ff;
    id_clr        = 1'b0;
    id_shift      = 1'b0;
    nxt_s.rst_out = 1'b1; // drives clear their flops while this is low
    nxt_s.rdata   = 8'h00;

    // shared wait timer: select setup in idle, phase time when busy
    if (!tmr_done) begin
      nxt_s.tmr = s_ff.tmr - 9'h001;
    end

    // drive control writes, refused while the id reader owns the lines
    if (reg_wr_i && reg_addr_i == `FDP_OFS_DRIVE_CTRL && !busy) begin
      nxt_s.ctrl = wr_ctrl; // bit layout of the control byte
      // a new motor level holds selects off for one setup time
      if (wr_ctrl.motor_n != s_ff.ctrl.motor_n) begin
        nxt_s.tmr = setup_val;
      end
      // direction moves only with step idle now and after
      if (!(s_ff.ctrl.step_n && wr_ctrl.step_n)) begin
        nxt_s.ctrl.dir = s_ff.ctrl.dir;
      end
    end

    // configuration writes
    if (reg_wr_i && reg_addr_i == `FDP_OFS_PORT_CFG) begin
      nxt_s.idx_en = reg_wdata_i[`FDP_BIT_IDX_EN];
      nxt_s.wgate  = reg_wdata_i[`FDP_BIT_WGATE];
    end

    // identification sequencer
    case (s_ff.st)
      ST_IDLE: begin
        if (reg_wr_i && reg_addr_i == `FDP_OFS_ID_CMD &&
            reg_wdata_i[`FDP_BIT_ID_START]) begin
          nxt_s.unit         = reg_wdata_i[1:0];
          nxt_s.ctrl.motor_n = 1'b1;
          nxt_s.ctrl.sel_n   = 4'hF;
          nxt_s.tmr          = setup_val;
          nxt_s.st           = ST_MON; // motor on first
        end
      end
      ST_MON: begin
        if (tmr_done) begin
          nxt_s.tmr = setup_val;
          nxt_s.st  = ST_MON_SEL;
        end
      end
      ST_MON_SEL: begin
        if (tmr_done) begin
          nxt_s.tmr = setup_val;
          nxt_s.st  = ST_MON_REL;
        end
      end
      ST_MON_REL: begin
        if (tmr_done) begin
          nxt_s.tmr = setup_val;
          nxt_s.st  = ST_MOFF; // then motor off
        end
      end
      ST_MOFF: begin
        if (tmr_done) begin
          nxt_s.tmr = setup_val;
          nxt_s.st  = ST_MOFF_SEL;
        end
      end
      ST_MOFF_SEL: begin
        if (tmr_done) begin
          nxt_s.tmr = setup_val;
          nxt_s.st  = ST_MOFF_REL;
        end
      end
      ST_MOFF_REL: begin
        // select rests inactive before the first bit
        if (tmr_done) begin
          id_clr      = 1'b1;
          nxt_s.bitno = 6'h00;
          nxt_s.tmr   = setup_val;
          nxt_s.st    = ST_BIT_SEL;
        end
      end
      ST_BIT_SEL: begin
        // sample ready at the end of the select window
        if (tmr_done) begin
          id_shift  = 1'b1;
          nxt_s.tmr = setup_val;
          nxt_s.st  = ST_BIT_REL;
        end
      end
      ST_BIT_REL: begin
        if (tmr_done) begin
          if (s_ff.bitno == 6'(ID_BITS - 1)) begin
            nxt_s.st = ST_IDLE; // all 32 bits
          end else begin
            nxt_s.bitno = s_ff.bitno + 6'h01;
            nxt_s.tmr   = setup_val;
            nxt_s.st    = ST_BIT_SEL;
          end
        end
      end
      default: begin
        nxt_s.st = ST_IDLE;
      end
    endcase

    // index falling edge raises a gated request pulse
    nxt_s.idx_prev = stat.index_n;
    nxt_s.idx_evt  = s_ff.idx_en && s_ff.idx_prev && !stat.index_n;

    // flux: write only under gate, read stream inverted
    nxt_s.wflux_n = ~(s_ff.wgate & write_flux_i);
    nxt_s.rflux   = ~stat.flux_n;

    // register reads, data valid in the following cycle only
    if (reg_rd_i) begin
      case (reg_addr_i)
        `FDP_OFS_DRIVE_CTRL: nxt_s.rdata = s_ff.ctrl;
        `FDP_OFS_DRIVE_STAT: begin
          // ready, track zero, protect, change in place
          nxt_s.rdata[`FDP_BIT_READY]  = stat.ready_n;
          nxt_s.rdata[`FDP_BIT_TRK0]   = stat.trk0_n;
          nxt_s.rdata[`FDP_BIT_WPROT]  = stat.wprot_n;
          nxt_s.rdata[`FDP_BIT_CHANGE] = stat.chg_n;
        end
        `FDP_OFS_PORT_CFG: begin
          nxt_s.rdata[`FDP_BIT_IDX_EN] = s_ff.idx_en;
          nxt_s.rdata[`FDP_BIT_WGATE]  = s_ff.wgate;
        end
        `FDP_OFS_ID_CMD: begin
          nxt_s.rdata[`FDP_BIT_ID_BUSY] = busy;
          nxt_s.rdata[1:0]              = s_ff.unit;
        end
        `FDP_OFS_ID_BYTE0: nxt_s.rdata = id_word[7:0];
        `FDP_OFS_ID_BYTE1: nxt_s.rdata = id_word[15:8];
        `FDP_OFS_ID_BYTE2: nxt_s.rdata = id_word[23:16];
        `FDP_OFS_ID_BYTE3: nxt_s.rdata = id_word[31:24];
        default:           nxt_s.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_ff          <= '0;
      s_ff.ctrl     <= fdp_drive_ctrl_s'(`FDP_RST_DRIVE_CTRL);
      s_ff.idx_prev <= 1'b1;
      s_ff.wflux_n  <= 1'b1;
      s_ff.st       <= ST_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line drivers

  // id reader select: only its unit, active in the select phases
  always_comb begin
    sel_fsm = 4'hF;
    if (s_ff.st == ST_MON_SEL || s_ff.st == ST_MOFF_SEL ||
        s_ff.st == ST_BIT_SEL) begin
      sel_fsm[s_ff.unit] = 1'b0;
    end
  end

  // selects stay off while a new motor level settles
  logic [3:0] sel_out;
  assign sel_out = busy ? sel_fsm :
                   (s_ff.ctrl.sel_n | {4{!tmr_done}});

  assign spindle_on_n_o = busy ? !(s_ff.st == ST_MON ||
                                   s_ff.st == ST_MON_SEL ||
                                   s_ff.st == ST_MON_REL)
                               : s_ff.ctrl.motor_n;

  // one internal and three external selects
  assign internal_unit_select_n_o  = sel_out[0];
  assign external_unit1_select_n_o = sel_out[1];
  assign external_unit2_select_n_o = sel_out[2];
  assign external_unit3_select_n_o = sel_out[3];

  assign head_side_n_o        = s_ff.ctrl.side_n;
  assign head_direction_o     = s_ff.ctrl.dir;
  assign head_move_pulse_n_o  = s_ff.ctrl.step_n;
  assign write_gate_n_o       = ~s_ff.wgate;
  assign write_flux_n_o       = s_ff.wflux_n;
  assign system_reset_out_n_o = s_ff.rst_out;
  assign read_flux_o          = s_ff.rflux;
  assign index_event_o        = s_ff.idx_evt;
  assign reg_rdata_o          = s_ff.rdata;

endmodule

//--- fdp_port_props.sv
// port-level checks for the floppy drive port control block
module fdp_port_props
  import fdp_pkg::*;
#(
  parameter int SETUP_CYC = 280
) (
  input wire logic       ref_clk_i,
  input wire logic       resetn_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       spindle_on_n_o,
  input wire logic       internal_unit_select_n_o,
  input wire logic       external_unit1_select_n_o,
  input wire logic       external_unit2_select_n_o,
  input wire logic       external_unit3_select_n_o,
  input wire logic       head_side_n_o,
  input wire logic       head_direction_o,
  input wire logic       head_move_pulse_n_o,
  input wire logic       write_gate_n_o,
  input wire logic       write_flux_n_o,
  input wire logic       write_flux_i,
  input wire logic       system_reset_out_n_o,
  input wire logic       index_n_i,
  input wire logic       index_event_o,
  input wire logic       read_flux_n_i,
  input wire logic       read_flux_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  logic [15:0] hold_ff;
  logic        spin_ff;
  wire  logic  sel_idle;
  assign sel_idle = internal_unit_select_n_o & external_unit1_select_n_o
                  & external_unit2_select_n_o & external_unit3_select_n_o;
  ////////////////////////////////////////////////////////////////////////
  // counts the select blanking window after a motor level change
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_ff <= '0;
      spin_ff <= 1'b1;
    end else begin
      spin_ff <= spindle_on_n_o;
      if (spindle_on_n_o != spin_ff) hold_ff <= 16'(SETUP_CYC - 1);
      else if (hold_ff != 16'h0) hold_ff <= hold_ff - 16'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  chk_reset_out: assert property (
    $past(resetn_i) |-> system_reset_out_n_o)
    else $error("reset out still low after release");
  chk_sel_blank: assert property (
    (spindle_on_n_o != spin_ff || hold_ff != 16'h0) |-> sel_idle)
    else $error("select active inside motor setup window");
  chk_stat_map: assert property (
    $past(reg_rd_i) && $past(reg_addr_i) == 3'h1
    |-> {reg_rdata_o[7:6], reg_rdata_o[1:0]} == 4'h0)
    else $error("status byte has spare bits set");
  chk_ctrl_map: assert property (
    $past(reg_rd_i) && $past(reg_addr_i) == 3'h0 |-> reg_rdata_o[2:0] ==
    {head_side_n_o, head_direction_o, head_move_pulse_n_o})
    else $error("control byte low bits differ from lines");
  chk_dir_hold: assert property (
    head_direction_o != $past(head_direction_o)
    |-> head_move_pulse_n_o && $past(head_move_pulse_n_o))
    else $error("direction moved while step active");
  chk_flux_gate: assert property (
    !write_flux_n_o |-> !$past(write_gate_n_o) && $past(write_flux_i))
    else $error("write flux without gate or cause");
  chk_flux_in: assert property (
    $past(resetn_i, 3) |-> read_flux_o == !$past(read_flux_n_i, 3))
    else $error("read flux not passed through");
  chk_idx_pulse: assert property (
    index_event_o |-> (!$past(index_n_i, 3) && $past(index_n_i, 4))
    ##1 !index_event_o)
    else $error("index request without index or too long");
endmodule

//--- fdp_sync2.sv
// two flip-flop synchroniser for drive status inputs
module fdp_sync2
  import fdp_pkg::*;
#(
  parameter int          W       = 6,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fdp_sync_s;

  fdp_sync_s s_ff;
  fdp_sync_s nxt_s;

  // first stage feeds only the second
  always_comb begin
    nxt_s    = s_ff;
    nxt_s.s1 = async_i;
    nxt_s.s2 = s_ff.s1;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_ff <= {RST_VAL, RST_VAL};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sync_o = s_ff.s2;

endmodule

//--- testbench.sv
// self-checking bench for the floppy drive port control block
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int          SETUP   = 4;
  localparam logic [31:0] ID_WORD = 32'h9A3C_E615; // arbitrary value
  logic       ref_clk_i, resetn_i, reg_wr_i, reg_rd_i, write_flux_i;
  logic [2:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, d;
  logic       spindle_on_n_o, internal_unit_select_n_o, head_side_n_o;
  logic       external_unit1_select_n_o, external_unit2_select_n_o;
  logic       external_unit3_select_n_o, head_direction_o, write_gate_n_o;
  logic       head_move_pulse_n_o, write_flux_n_o, system_reset_out_n_o;
  logic       ready_n_i, outer_cylinder_n_i, write_protected_n_i;
  logic       media_changed_n_i, index_n_i, read_flux_n_i;
  logic       read_flux_o, index_event_o;
  logic [3:0] e4;
  logic [7:0] stp_a [6] = '{8'h6C, 8'h6D, 8'h6C, 8'h6D, 8'h6C, 8'h6D};
  logic [7:0] stp_b [7] = '{8'h6F, 8'h6E, 8'h6D, 8'h6C, 8'h6F, 8'h6E, 8'h6F};
  int         errors = 0;
  int         checked = 0;
  int         n;
  ////////////////////////////////////////////////////////////////////////
  fdp_port_ctrl #(.SETUP_CYC(SETUP)) dut (.*);
  fdp_drive_model #(.ID_WORD(ID_WORD)) drive (
    .clk_i     (ref_clk_i),
    .rst_n_i   (system_reset_out_n_o),
    .sel_n_i   (external_unit1_select_n_o),
    .motor_n_i (spindle_on_n_o),
    .step_n_i  (head_move_pulse_n_o),
    .dir_i     (head_direction_o),
    .ready_n_o (ready_n_i),
    .trk0_n_o  (outer_cylinder_n_i),
    .wprot_n_o (write_protected_n_i),
    .chg_n_o   (media_changed_n_i),
    .index_n_o (index_n_i),
    .flux_n_o  (read_flux_n_i)
  );
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  // register port access and comparison
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    rd(a, d);
    chk(d, e);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard
  initial begin
    #50us;
    errors++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn_i, reg_wr_i, reg_rd_i, write_flux_i} <= '0;
    {reg_addr_i, reg_wdata_i} <= '0;
    repeat (10) @(posedge ref_clk_i);
    chk(system_reset_out_n_o, 1'b0);
    repeat (10) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    chk(system_reset_out_n_o, 1'b1);
    rchk(3'h0, 8'hFD);
    rchk(3'h2, 8'h00);
    rchk(3'h1, 8'h3C);
    // motor on with unit 1: select waits out the setup time
    wr(3'h0, 8'h6D);
    #1 chk(external_unit1_select_n_o, 1'b1);
    repeat (SETUP + 2) @(posedge ref_clk_i);
    #1 chk(external_unit1_select_n_o, 1'b0);
    repeat (4) @(posedge ref_clk_i);
    rchk(3'h1, 8'h08);
    // three steps inward, then outward with refused direction writes
    foreach (stp_a[i]) wr(3'h0, stp_a[i]);
    chk(drive.cyl, 3);
    repeat (4) @(posedge ref_clk_i);
    rchk(3'h1, 8'h1C);
    foreach (stp_b[i]) wr(3'h0, stp_b[i]);
    #1 chk(head_direction_o, 1'b1);
    chk(drive.cyl, 0);
    repeat (4) @(posedge ref_clk_i);
    rchk(3'h1, 8'h0C);
    // each select bit reaches its own line
    for (int b = 3; b < 7; b++) begin
      wr(3'h0, 8'h7F ^ (8'h01 << b));
      repeat (2) @(posedge ref_clk_i);
      e4 = ~(4'h1 << (b - 3));
      chk({external_unit3_select_n_o, external_unit2_select_n_o,
           external_unit1_select_n_o, internal_unit_select_n_o}, e4);
    end
    wr(3'h0, 8'h6B);
    #1 chk(head_side_n_o, 1'b0);
    rchk(3'h0, 8'h6B);
    // write flux only under the gate
    wr(3'h2, 8'h02);
    #1 chk(write_gate_n_o, 1'b0);
    @(posedge ref_clk_i) write_flux_i <= 1'b1;
    @(posedge ref_clk_i) write_flux_i <= 1'b0;
    #1 chk(write_flux_n_o, 1'b0);
    wr(3'h2, 8'h01);
    @(posedge ref_clk_i) write_flux_i <= 1'b1;
    @(posedge ref_clk_i) write_flux_i <= 1'b0;
    #1 chk(write_flux_n_o, 1'b1);
    // index request once enabled
    n = 0;
    while (index_event_o !== 1'b1 && n < 200) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    chk(index_event_o, 1'b1);
    // read-only places ignore writes; control ignored while id busy
    wr(3'h1, 8'hFF);
    wr(3'h4, 8'h00);
    wr(3'h3, 8'h81);
    wr(3'h0, 8'h00);
    n = 0;
    do begin
      rd(3'h3, d);
      n++;
    end while (d[7] !== 1'b0 && n < 400);
    chk(d, 8'h01);
    for (int i = 0; i < 4; i++) rchk(3'(4 + i), ID_WORD[8*i +: 8]);
    rchk(3'h0, 8'hFB);
    chk(spindle_on_n_o, 1'b1);
    results();
  end
endmodule

bind fdp_port_ctrl fdp_port_props #(.SETUP_CYC(SETUP_CYC)) u_props (.*);
